// File: core/rtcc_ctrl.sv
// Control, status and interrupt logic of a byte-wide real-time clock.
// Assumes a host on a multiplexed byte bus, synchronous to sys_clk, and a
// separate time counter that applies the update, format and daylight pulses.
// Contract
// RULE1 - UPDATE_PENDING_FLAG low guarantees 244 us before transfer.
// RULE2 - UPDATE_PENDING_FLAG read-only; SET blocks updates, clears UPDATE_PENDING_FLAG.
// RULE3 - Only 010 runs; 11x holds divider reset.
// RULE4 - First update 500 ms after run pattern.
// RULE5 - Rate selects divider tap, shared, survives reset.
// RULE6 - SET high stops transfers; reset leaves SET.
// RULE7 - PERIODIC_IRQ_ENABLE gates PF; PF still sets; reset clears.
// RULE8 - Alarm match with don't-care sets AF.
// RULE9 - UPDATE_DONE_IRQ_ENABLE gates UF; reset or SET clear.
// RULE10 - SQUARE_WAVE_ENABLE toggles square wave, else low.
// RULE11 - Data-format bit untouched by reset.
// RULE12 - Hour-format bit untouched by reset.
// RULE13 - Daylight jumps at 1:59:59 AM spring, fall.
// RULE14 - Sunday test at midnight needs enable set.
// RULE15 - INTERRUPT_SUMMARY_FLAG is OR of gated flags; drives IRQ.
// RULE16 - PF sets on selected tap edge.
// RULE17 - UF sets at end of each update.
// RULE18 - Flag byte low nibble reads zero.
// RULE19 - Backup-valid bit read-only, others zero.
// RULE20 - Flag read snapshots, clears, holds new events.
// RULE21 - Enabling over a set flag asserts IRQ.
// RULE22 - Control registers reachable during updates.
// RULE23 - Transfer follows UPDATE_PENDING_FLAG rise by 244 us.
// RULE24 - Flag, backup bytes and UPDATE_PENDING_FLAG read-only.
// RULE25 - Read-only bits ignore writes, others kept.
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_defines.svh"

module rtcc_ctrl (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire rtcc_pkg::rtcc_bus_req_t bus_req,
	input wire logic xtal_tick,
	input wire rtcc_pkg::rtcc_hms_t cur_time,
	input wire rtcc_pkg::rtcc_hms_t alarm_time,
	input wire logic midnight_pulse,
	input wire logic spring_sunday,
	input wire logic fall_sunday,
	input wire logic backup_ok,
	output logic [7:0] reg_rdata_q,
	output logic irq_n_q,
	output logic square_wave_out_q,
	output logic update_strobe_q,
	output logic osc_enable_q,
	output logic dst_forward_q,
	output logic dst_back_q,
	output rtcc_pkg::rtcc_fmt_t fmt_q
);

	// ==========================================================
	// Control state. Bits that reset must leave alone start from a
	// power-up value instead.
	logic update_pending_flag_q = 1'b0; // Update in progress.
	logic [2:0] osc_ctrl_q = 3'h0; // Oscillator control pattern.
	logic [3:0] rate_sel_q = 4'h0; // Divider tap select.
	logic set_q = 1'b0; // Update inhibit.
	logic periodic_irq_enable_q; // Cleared by reset.
	logic alarm_irq_enable_q; // Cleared by reset.
	logic update_done_irq_enable_q; // Cleared by reset or inhibit.
	logic square_wave_enable_q; // Cleared by reset.
	logic binary_format_select_q = 1'b0; // Untouched by reset.
	logic hour24_q = 1'b0; // Untouched by reset.
	logic daylight_adjust_enable_q = 1'b0; // Untouched by reset.
	logic backup_valid_bit_q = 1'b0; // Follows the backup source.
	logic [14:0] div_q = 15'h0000; // Fifteen-stage countdown chain.
	logic tap_prev_q; // Previous tap level, for edge detection.
	logic upd_end_q; // One cycle after each rollover, even with transfers inhibited.
	rtcc_pkg::rtcc_flags_t flags_q; // Visible event flags.
	rtcc_pkg::rtcc_flags_t pend_q; // Events caught during a flag read.
	logic rd_active_q; // A read cycle is under way.
	logic spring_armed_q; // Spring jump armed at midnight.
	logic fall_armed_q; // Fall return armed at midnight.
	logic fall_done_q; // Fall return already taken today.

	// ==========================================================
	// Bus decode.
	wire rd_start = bus_req.rd & ~rd_active_q;
	wire rd_end = ~bus_req.rd & rd_active_q;
	wire wr_a = bus_req.wr & (bus_req.addr == `RTCC_OFS_RATE);
	wire wr_b = bus_req.wr & (bus_req.addr == `RTCC_OFS_CTRL);
	wire rd_flag_start = rd_start & (bus_req.addr == `RTCC_OFS_FLAG);
	logic rd_active_flag_q; // The read in progress targets the flag byte.
	wire rd_flag_end = rd_end & rd_active_flag_q;
	wire [2:0] dv_new = bus_req.wdata[`RTCC_A_DV_HI:`RTCC_A_DV_LO];
	wire set_new = bus_req.wdata[`RTCC_B_SET];

	// ==========================================================
	// Oscillator and countdown chain decode.
	wire dv_run = (osc_ctrl_q == `RTCC_DV_RUN); // [RULE3]
	wire dv_hold = (osc_ctrl_q[2:1] == `RTCC_DV_HOLD_MSB); // [RULE3]
	wire enter_run = wr_a & (dv_new == `RTCC_DV_RUN) & ~dv_run;
	wire tick_run = xtal_tick & dv_run;
	wire uip_rise = tick_run & (div_q == 15'(`RTCC_UIP_START - 1)); // [RULE1]
	wire rollover = tick_run & (div_q == `RTCC_DIV_LAST);

	// ==========================================================
	// Rate select: codes 1 and 2 repeat the 256 Hz and 128 Hz taps,
	// codes 3 to 15 walk the chain from 8.192 kHz to 2 Hz.
	logic [3:0] tap_bit;
	always_comb begin
		case (rate_sel_q)
			`RTCC_RS_256HZ: tap_bit = 4'h6;
			`RTCC_RS_128HZ: tap_bit = 4'h7;
			default: tap_bit = 4'(rate_sel_q - 4'h2);
		endcase
	end
	wire tap_on = (rate_sel_q != `RTCC_RS_NONE); // [RULE5]
	wire tap_lvl = tap_on & div_q[tap_bit]; // [RULE5]
	wire pf_event = tap_lvl & ~tap_prev_q; // [RULE16]

	// ==========================================================
	// Alarm compare with don't-care codes.
	wire m_s = (alarm_time.sec[7:6] == `RTCC_ALM_ANY) | (alarm_time.sec == cur_time.sec);
	wire m_m = (alarm_time.min[7:6] == `RTCC_ALM_ANY) | (alarm_time.min == cur_time.min);
	wire m_h = (alarm_time.hour[7:6] == `RTCC_ALM_ANY) | (alarm_time.hour == cur_time.hour);
	wire af_event = upd_end_q & m_s & m_m & m_h; // [RULE8]
	wire uf_event = upd_end_q; // [RULE17]

	// Daylight adjust trigger at 1:59:59 AM in the current format.
	wire [7:0] dst_ms = binary_format_select_q ? `RTCC_DST_MS_BIN : `RTCC_DST_MS_BCD;
	wire at_dst_time = (cur_time.hour == `RTCC_DST_HOUR) & (cur_time.min == dst_ms) &
		(cur_time.sec == dst_ms);
	wire transfer = rollover & ~set_q; // [RULE6]

	// ==========================================================
	// Interrupt summary, recomputed every cycle so that late enables act.
	rtcc_pkg::rtcc_flags_t events;
	assign events = '{pf: pf_event, af: af_event, uf: uf_event};
	wire interrupt_summary_flag = (flags_q.pf & periodic_irq_enable_q) | (flags_q.af & alarm_irq_enable_q) |
		(flags_q.uf & update_done_irq_enable_q); // [RULE15] [RULE21]

	// Read data for each register; reserved bits read zero.
	wire [7:0] rd_a = {update_pending_flag_q, osc_ctrl_q, rate_sel_q}; // [RULE24]
	wire [7:0] rd_b = {set_q, periodic_irq_enable_q, alarm_irq_enable_q,
		update_done_irq_enable_q, square_wave_enable_q, binary_format_select_q,
		hour24_q, daylight_adjust_enable_q};
	wire [7:0] rd_c = {interrupt_summary_flag, flags_q.pf, flags_q.af, flags_q.uf, 4'h0}; // [RULE18]
	wire [7:0] rd_d = {backup_valid_bit_q, 7'h00}; // [RULE19] [RULE24]
	logic [7:0] rd_mux;
	always_comb begin
		case (bus_req.addr)
			`RTCC_OFS_RATE: rd_mux = rd_a;
			`RTCC_OFS_CTRL: rd_mux = rd_b;
			`RTCC_OFS_FLAG: rd_mux = rd_c;
			`RTCC_OFS_BKUP: rd_mux = rd_d;
			default: rd_mux = `RTCC_ZERO_BYTE;
		endcase
	end

	// ==========================================================
	// Rate and oscillator byte. The update flag has no write path, and
	// none of these bits see reset.
	always_ff @(posedge sys_clk) begin
		if (wr_a) begin
			osc_ctrl_q <= dv_new; // [RULE25] [RULE22]
			rate_sel_q <= bus_req.wdata[`RTCC_A_RS_HI:`RTCC_A_RS_LO]; // [RULE5]
		end
	end

	// Update-in-progress flag: rises a fixed lead before rollover,
	// falls at rollover, and is forced low by the inhibit.
	always_ff @(posedge sys_clk) begin
		if (set_q | (wr_b & set_new)) begin
			update_pending_flag_q <= 1'b0; // [RULE2]
		end else if (uip_rise) begin
			update_pending_flag_q <= 1'b1; // [RULE23]
		end else if (rollover | ~dv_run) begin
			update_pending_flag_q <= 1'b0;
		end
	end

	// Countdown chain: runs on ticks only with the run pattern, sits at
	// zero otherwise, and starts half a second short of rollover on entry.
	always_ff @(posedge sys_clk) begin
		if (enter_run) begin
			div_q <= 15'(`RTCC_DIV_LOAD); // [RULE4]
		end else if (!dv_run) begin
			div_q <= 15'h0000; // [RULE3]
		end else if (tick_run) begin
			div_q <= div_q + 15'h0001;
		end
	end

	// Oscillator runs for the run pattern and the hold pattern.
	always_ff @(posedge sys_clk) begin
		osc_enable_q <= dv_run | dv_hold; // [RULE3]
	end

	// ==========================================================
	// Format and inhibit bits: written by software only.
	always_ff @(posedge sys_clk) begin
		if (wr_b) begin
			set_q <= set_new; // [RULE6]
			binary_format_select_q <= bus_req.wdata[`RTCC_B_DM]; // [RULE11]
			hour24_q <= bus_req.wdata[`RTCC_B_H24]; // [RULE12]
			daylight_adjust_enable_q <= bus_req.wdata[`RTCC_B_DSE]; // [RULE14]
		end
	end

	// Interrupt enables: cleared by reset; the update enable also falls
	// when the inhibit goes high.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			periodic_irq_enable_q <= 1'b0; // [RULE7]
			alarm_irq_enable_q <= 1'b0; // [RULE8]
			update_done_irq_enable_q <= 1'b0; // [RULE9]
			square_wave_enable_q <= 1'b0; // [RULE10]
		end else if (wr_b) begin
			periodic_irq_enable_q <= bus_req.wdata[`RTCC_B_PIE];
			alarm_irq_enable_q <= bus_req.wdata[`RTCC_B_AIE];
			update_done_irq_enable_q <= bus_req.wdata[`RTCC_B_UIE] & ~(set_new & ~set_q); // [RULE9]
			square_wave_enable_q <= bus_req.wdata[`RTCC_B_SQUARE_WAVE_ENABLE];
		end
	end

	// Format settings for the counter.
	always_ff @(posedge sys_clk) begin
		fmt_q <= '{binary_format_select: binary_format_select_q, hour24: hour24_q,
			daylight_adjust_enable: daylight_adjust_enable_q};
	end

	// Backup status follows the health input.
	always_ff @(posedge sys_clk) begin
		backup_valid_bit_q <= backup_ok; // [RULE19]
	end

	// ==========================================================
	// Tap edge detector, square wave and update timing.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tap_prev_q <= 1'b0;
			upd_end_q <= 1'b0;
			update_strobe_q <= 1'b0;
			square_wave_out_q <= 1'b0;
		end else begin
			tap_prev_q <= tap_lvl;
			upd_end_q <= rollover; // [RULE17]
			update_strobe_q <= transfer; // [RULE6]
			square_wave_out_q <= square_wave_enable_q & tap_lvl; // [RULE10]
		end
	end

	// ==========================================================
	// Flags. A flag-byte read start clears the visible flags; events that land
	// during the read wait in the pending set and post at the read's end.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_q <= '0;
			pend_q <= '0;
		end else if (rd_flag_start) begin
			flags_q <= '0; // [RULE20]
			pend_q <= events;
		end else if (rd_active_flag_q) begin
			pend_q <= pend_q | events; // [RULE20]
			if (rd_flag_end) begin
				flags_q <= pend_q | events;
				pend_q <= '0;
			end
		end else begin
			flags_q <= flags_q | events; // [RULE16] [RULE7]
		end
	end

	// Read cycle tracking and read data capture at the start of a read.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_active_q <= 1'b0;
			rd_active_flag_q <= 1'b0;
			reg_rdata_q <= `RTCC_ZERO_BYTE;
		end else begin
			rd_active_q <= bus_req.rd;
			if (rd_start) begin
				rd_active_flag_q <= (bus_req.addr == `RTCC_OFS_FLAG);
				reg_rdata_q <= rd_mux; // [RULE20] [RULE22]
			end else if (rd_end) begin
				rd_active_flag_q <= 1'b0;
			end
		end
	end

	// Active-low interrupt follows the summary.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~interrupt_summary_flag; // [RULE15]
		end
	end

	// ==========================================================
	// Daylight adjust: the Sunday test happens at midnight only while
	// enabled; the jump fires on the transfer that leaves 1:59:59 AM.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			spring_armed_q <= 1'b0;
			fall_armed_q <= 1'b0;
			fall_done_q <= 1'b0;
			dst_forward_q <= 1'b0;
			dst_back_q <= 1'b0;
		end else begin
			if (midnight_pulse) begin
				spring_armed_q <= daylight_adjust_enable_q & spring_sunday; // [RULE14]
				fall_armed_q <= daylight_adjust_enable_q & fall_sunday; // [RULE14]
				fall_done_q <= 1'b0;
			end
			dst_forward_q <= transfer & daylight_adjust_enable_q & spring_armed_q & at_dst_time; // [RULE13]
			dst_back_q <= transfer & daylight_adjust_enable_q & fall_armed_q & ~fall_done_q &
				at_dst_time; // [RULE13]
			if (transfer & fall_armed_q & at_dst_time) begin
				fall_done_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks.
	sequence s_flag_read;
		rd_flag_start ##1 1'b1;
	endsequence
	sequence s_enable_late;
		$rose(periodic_irq_enable_q) && flags_q.pf;
	endsequence

	a_uip_lead: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
		(rollover && !set_q) |-> update_pending_flag_q)
		else $error("transfer without update flag lead");
	a_set_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
		set_q |=> (!update_pending_flag_q && !update_strobe_q))
		else $error("inhibit did not block update");
	a_div_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
		(!dv_run && !enter_run) |=> (div_q == 15'h0000))
		else $error("divider ran without run pattern");
	a_first_upd: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
		enter_run |=> (div_q == 15'h4000))
		else $error("run entry did not load half second");
	a_uie_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
		(wr_b && set_new && !set_q) |=> !update_done_irq_enable_q)
		else $error("update enable survived inhibit");
	a_sqw_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE10]
		!square_wave_enable_q |=> !square_wave_out_q)
		else $error("square wave not held low");
	a_irq_out: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE15]
		interrupt_summary_flag |=> !irq_n_q)
		else $error("interrupt output not driven");
	a_pf_edge: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE16]
		(pf_event && !rd_active_flag_q && !rd_flag_start) |=> flags_q.pf)
		else $error("periodic flag missed tap edge");
	a_rd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE20]
		s_flag_read |-> (flags_q == '0) && (reg_rdata_q[3:0] == 4'h0))
		else $error("flag read did not clear");
	a_late_en: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE21]
		s_enable_late |=> !irq_n_q)
		else $error("late enable did not assert interrupt");

endmodule
`default_nettype wire

// File: core/rtcc_defines.svh
// Constants for the real-time-clock control block: offsets, bit positions,
// reset values and timebase counts.
// Assumes the crystal timebase arrives as a one-cycle tick at 32.768 kHz.
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH

// ==========================================================
// Register offsets on the byte-wide multiplexed bus.
`define RTCC_OFS_RATE 7'h0A
`define RTCC_OFS_CTRL 7'h0B
`define RTCC_OFS_FLAG 7'h0C
`define RTCC_OFS_BKUP 7'h0D

// ==========================================================
// Bit positions of the rate and oscillator control byte.
`define RTCC_A_UIP 7
`define RTCC_A_DV_HI 6
`define RTCC_A_DV_LO 4
`define RTCC_A_RS_HI 3
`define RTCC_A_RS_LO 0
// Bit positions of the interrupt and format control byte.
`define RTCC_B_SET 7
`define RTCC_B_PIE 6
`define RTCC_B_AIE 5
`define RTCC_B_UIE 4
`define RTCC_B_SQUARE_WAVE_ENABLE 3
`define RTCC_B_DM 2
`define RTCC_B_H24 1
`define RTCC_B_DSE 0

// ==========================================================
// Oscillator patterns and power-up values.
`define RTCC_DV_RUN 3'h2
`define RTCC_DV_HOLD_MSB 2'h3
`define RTCC_RS_NONE 4'h0
`define RTCC_RS_256HZ 4'h1
`define RTCC_RS_128HZ 4'h2
`define RTCC_ZERO_BYTE 8'h00

// ==========================================================
// Timebase: crystal rate, update lead time and first-update delay.
`define RTCC_XTAL_HZ 32768
`define RTCC_DIV_BITS 15
`define RTCC_UIP_LEAD_US 244
`define RTCC_UIP_LEAD_TICKS ((`RTCC_UIP_LEAD_US * `RTCC_XTAL_HZ + 999999) / 1000000)
`define RTCC_FIRST_UPD_MS 500
`define RTCC_FIRST_UPD_TICKS (`RTCC_FIRST_UPD_MS * `RTCC_XTAL_HZ / 1000)
`define RTCC_DIV_LOAD (`RTCC_XTAL_HZ - `RTCC_FIRST_UPD_TICKS)
`define RTCC_UIP_START (`RTCC_XTAL_HZ - `RTCC_UIP_LEAD_TICKS)
`define RTCC_DIV_LAST 15'h7FFF

// ==========================================================
// Daylight adjust trigger time, 1:59:59 AM, in both data formats.
`define RTCC_DST_HOUR 8'h01
`define RTCC_DST_MS_BCD 8'h59
`define RTCC_DST_MS_BIN 8'h3B
// An alarm byte with both top bits set matches any time byte.
`define RTCC_ALM_ANY 2'h3

`endif

// File: core/rtcc_pkg.sv
// Types shared by the real-time-clock control block and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package rtcc_pkg;

	// ==========================================================
	// Host bus request: one register access per strobe.
	typedef struct packed {
		logic rd; // Read strobe, held for the whole read cycle.
		logic wr; // Write strobe.
		logic [6:0] addr; // Byte address.
		logic [7:0] wdata; // Write data.
	} rtcc_bus_req_t;

	// Seconds, minutes and hours bytes, as stored by the counter.
	typedef struct packed {
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcc_hms_t;

	// The three event flags.
	typedef struct packed {
		logic pf; // Periodic event.
		logic af; // Alarm match.
		logic uf; // Update ended.
	} rtcc_flags_t;

	// Format settings handed to the time counter.
	typedef struct packed {
		logic binary_format_select;
		logic hour24;
		logic daylight_adjust_enable;
	} rtcc_fmt_t;

endpackage

// File: verification/rtcc_host_model.sv
// Host processor model that drives the byte-wide register bus.
// Assumes requests are taken on rising sys_clk edges, read data one cycle later.
`timescale 1ns/10ps
`default_nettype none

module rtcc_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata_q,
	output var rtcc_pkg::rtcc_bus_req_t bus_req
);
	// ==========================================================
	// Bus state
	// The bus starts idle so the block sees no request before reset ends.
	initial begin
		bus_req = '0;
	end

	// Writes one byte; the strobe and data stand until the taking edge.
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		// Released data is inverted so a stale byte is never mistaken for valid.
		bus_req.wdata <= ~d;
	endtask

	// Reads one byte; the strobe drops after the data is taken, so reads are spaced.
	task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge sys_clk);
		@(posedge sys_clk);
		d = reg_rdata_q;
		bus_req.rd <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the clock control block with a host bus model.
// Assumes the crystal tick is held high, so the divider counts every cycle.
`timescale 1ns/10ps
`default_nettype none
`include "rtcc_defines.svh"

module tb_top;
	// ==========================================================
	// Signals
	logic sys_clk, rst_n, xtal_tick, backup_ok, midnight_pulse, spring_sunday;
	int n_fwd = 0, n_back = 0;
	rtcc_pkg::rtcc_bus_req_t bus_req;
	rtcc_pkg::rtcc_hms_t cur_time, alarm_time;
	rtcc_pkg::rtcc_fmt_t fmt_q;
	logic [7:0] reg_rdata_q, rdv;
	logic irq_n_q, square_wave_out_q, update_strobe_q, osc_enable_q, dst_forward_q, dst_back_q;
	int n_mismatch = 0, total_checks = 0, cyc = 0, n_strobe = 0, t_s = 0;

	rtcc_ctrl i_rtcc_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .xtal_tick(xtal_tick),
		.cur_time(cur_time), .alarm_time(alarm_time), .midnight_pulse(midnight_pulse),
		.spring_sunday(spring_sunday),
		.fall_sunday(1'b0), .backup_ok(backup_ok), .reg_rdata_q(reg_rdata_q), .irq_n_q(irq_n_q),
		.square_wave_out_q(square_wave_out_q), .update_strobe_q(update_strobe_q),
		.osc_enable_q(osc_enable_q), .dst_forward_q(dst_forward_q), .dst_back_q(dst_back_q),
		.fmt_q(fmt_q));
	rtcc_host_model i_rtcc_host_model (.sys_clk(sys_clk), .reg_rdata_q(reg_rdata_q), .bus_req(bus_req));

	// Clock of 25 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Counts cycles and update transfers, keeping the cycle of the last one.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (update_strobe_q === 1'b1) begin
			n_strobe <= n_strobe + 1;
			t_s <= cyc;
		end
		if (dst_forward_q === 1'b1) begin
			n_fwd <= n_fwd + 1;
		end
		if (dst_back_q === 1'b1) begin
			n_back <= n_back + 1;
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_rtcc_host_model.wr_reg(a, d);
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		i_rtcc_host_model.rd_reg(a, rdv);
		check8(rdv, exp);
	endtask
	// Waits a bounded time for the interrupt line to go low.
	task automatic wait_irq(input int n);
		while (irq_n_q !== 1'b0 && n > 0) begin
			@(posedge sys_clk);
			n--;
		end
		check1(irq_n_q, 1'b0);
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_vals;
		rd_chk(`RTCC_OFS_CTRL, 8'h00);
		rd_chk(`RTCC_OFS_FLAG, 8'h00);
		rd_chk(`RTCC_OFS_BKUP, 8'h80);
		rd_chk(7'h20, 8'h00); // Unmapped address reads zero.
		check1(irq_n_q, 1'b1);
	endtask

	// Read-only bits ignore writes; pattern 111 runs the oscillator only.
	task automatic t_read_only;
		wr(`RTCC_OFS_RATE, 8'hFF);
		wr(`RTCC_OFS_FLAG, 8'hFF);
		wr(`RTCC_OFS_BKUP, 8'hFF);
		rd_chk(`RTCC_OFS_RATE, 8'h7F);
		check1(osc_enable_q, 1'b1);
		rd_chk(`RTCC_OFS_FLAG, 8'h00);
		rd_chk(`RTCC_OFS_BKUP, 8'h80);
		wr(`RTCC_OFS_RATE, 8'h50);
		repeat (2) @(posedge sys_clk);
		check1(osc_enable_q, 1'b0);
	endtask

	// The periodic flag sets with its enable low, then raises the line when enabled.
	task automatic t_periodic;
		wr(`RTCC_OFS_RATE, 8'h23);
		repeat (16) @(posedge sys_clk);
		rd_chk(`RTCC_OFS_FLAG, 8'h40);
		wr(`RTCC_OFS_CTRL, 8'h40);
		wait_irq(6);
		rd_chk(`RTCC_OFS_FLAG, 8'hC0);
		wr(`RTCC_OFS_RATE, 8'h20);
		i_rtcc_host_model.rd_reg(`RTCC_OFS_FLAG, rdv);
		repeat (16) @(posedge sys_clk);
		rd_chk(`RTCC_OFS_FLAG, 8'h00);
		check1(irq_n_q, 1'b1);
		wr(`RTCC_OFS_CTRL, 8'h00);
	endtask

	// The square wave follows tap one, a period of four ticks, and is low when off.
	task automatic t_square;
		int n;
		logic hi;
		wr(`RTCC_OFS_RATE, 8'h23);
		wr(`RTCC_OFS_CTRL, 8'h08);
		n = 0;
		while (square_wave_out_q !== 1'b0 && n < 16) begin
			@(posedge sys_clk);
			n++;
		end
		while (square_wave_out_q !== 1'b1 && n < 32) begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (square_wave_out_q !== 1'b0 && n < 16);
		while (square_wave_out_q !== 1'b1 && n < 16) begin
			@(posedge sys_clk);
			n++;
		end
		check8(n[7:0], 8'h04);
		check1(irq_n_q, 1'b1);
		wr(`RTCC_OFS_CTRL, 8'h00);
		repeat (3) @(posedge sys_clk);
		hi = 1'b0;
		repeat (16) begin
			@(posedge sys_clk);
			hi = hi | square_wave_out_q;
		end
		check1(hi, 1'b0);
	endtask

	// Restart from hold, then time the first update against the update flag.
	task automatic t_update;
		int n, t_w, t_lo, t_hi;
		wr(`RTCC_OFS_RATE, 8'h60);
		wr(`RTCC_OFS_RATE, 8'h20);
		t_w = cyc;
		wr(`RTCC_OFS_CTRL, 8'h10);
		i_rtcc_host_model.rd_reg(`RTCC_OFS_FLAG, rdv);
		repeat (16330) @(posedge sys_clk);
		t_hi = 0;
		t_lo = 0;
		// Polling also shows the registers stay reachable around the update.
		repeat (24) begin
			if (t_hi == 0) begin
				i_rtcc_host_model.rd_reg(`RTCC_OFS_RATE, rdv);
				if (rdv[7] === 1'b1) t_hi = cyc;
				else t_lo = cyc;
			end
		end
		n = 0;
		while (n_strobe == 0 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		check1(n_strobe == 1, 1'b1);
		check1((t_s - t_w) >= 16383 && (t_s - t_w) <= 16392, 1'b1);
		check1((t_s - t_lo) >= 8, 1'b1);
		check1(t_hi != 0 && (t_s - t_hi) >= 4 && (t_s - t_hi) <= 10, 1'b1);
		wait_irq(6);
		rd_chk(`RTCC_OFS_FLAG, 8'hB0);
		repeat (2) @(posedge sys_clk);
		check1(irq_n_q, 1'b1);
	endtask

	// The update inhibit clears its enable and blocks transfers for a whole second.
	task automatic t_set_hold;
		int ns;
		alarm_time <= 24'h05_0000;
		wr(`RTCC_OFS_CTRL, 8'h90);
		rd_chk(`RTCC_OFS_CTRL, 8'h80);
		rd_chk(`RTCC_OFS_RATE, 8'h20);
		ns = n_strobe;
		repeat (33000) @(posedge sys_clk);
		check1(n_strobe == ns, 1'b1);
		rd_chk(`RTCC_OFS_FLAG, 8'h10);
		wr(`RTCC_OFS_CTRL, 8'h00);
	endtask

	// Spring Sunday armed at midnight: the next transfer out of 1:59:59 AM jumps forward.
	task automatic t_dst;
		int ns, n;
		spring_sunday <= 1'b1;
		wr(`RTCC_OFS_CTRL, 8'h01);
		midnight_pulse <= 1'b1;
		@(posedge sys_clk);
		midnight_pulse <= 1'b0;
		cur_time <= 24'h01_5959;
		ns = n_strobe;
		n = 0;
		while (n_strobe == ns && n < 33000) begin
			@(posedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		check1(n_strobe == ns + 1, 1'b1);
		check1(n_fwd == 1 && n_back == 0, 1'b1);
		spring_sunday <= 1'b0;
		cur_time <= '0;
		wr(`RTCC_OFS_CTRL, 8'h00);
	endtask

	// Reset clears the enables but keeps rate and format bits; the backup bit follows its source.
	task automatic t_reset_keep;
		wr(`RTCC_OFS_RATE, 8'h2F);
		wr(`RTCC_OFS_CTRL, 8'h7F);
		repeat (2) @(posedge sys_clk);
		check8({5'h00, fmt_q}, 8'h07);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd_chk(`RTCC_OFS_RATE, 8'h2F);
		rd_chk(`RTCC_OFS_CTRL, 8'h07);
		check1(irq_n_q, 1'b1);
		backup_ok <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rd_chk(`RTCC_OFS_BKUP, 8'h00);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		xtal_tick = 1'b0;
		backup_ok = 1'b1;
		midnight_pulse = 1'b0;
		spring_sunday = 1'b0;
		cur_time = '0;
		alarm_time = 24'hC0_C0C0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		xtal_tick <= 1'b1;
		t_reset_vals();
		t_read_only();
		t_periodic();
		t_square();
		t_update();
		t_set_hold();
		t_dst();
		t_reset_keep();
		stop_test();
	end

	// The tests take about 82000 cycles; a hang is cut off after that.
	initial begin
		repeat (99000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire
